// *** include/dcg_consts.svh ***
`ifndef DCG_CONSTS_SVH
`define DCG_CONSTS_SVH

// special-function register addresses
`define DCG_ADDR_LINE_VOL   8'hbb
`define DCG_ADDR_MIC_VOL    8'hbc
`define DCG_ADDR_GAIN_CTRL  8'hc7

// reset values
`define DCG_VOL_RESET       8'h00
`define DCG_CTRL_RESET      8'h00

// implemented-bit masks, spare bits excluded
`define DCG_VOL_MASK        8'hc8
`define DCG_CTRL_MASK       8'h36

// field positions
`define DCG_VOL_TX_HI       7
`define DCG_VOL_TX_LO       6
`define DCG_VOL_RX_BIT      3
`define DCG_CTRL_LINE_HI    5
`define DCG_CTRL_LINE_SEL   4
`define DCG_CTRL_MIC_AMP    2
`define DCG_CTRL_MIC_LO     1

// timing
`define DCG_CLK_HZ          100000000
`define DCG_FS_HZ           8000
`define DCG_DECIM_RATIO     128

// fixed decimator gain, 3.14 dB as 735/512
`define DCG_DEC_GAIN_NUM    735
`define DCG_DEC_GAIN_SHIFT  9

// sample word full scale
`define DCG_PCM_POS_FS      16'h7fff
`define DCG_PCM_NEG_FS      16'h8000

`endif

// *** include/dcg_pkg.sv ***
package dcg_pkg;

  typedef enum logic [2:0] {
    DCG_RX_7DB  = 3'b000,
    DCG_RX_23DB = 3'b001,
    DCG_RX_35DB = 3'b010,
    DCG_RX_38DB = 3'b011,
    DCG_RX_50DB = 3'b100
  } dcg_rx_gain_t;

  typedef enum logic [1:0] {
    DCG_TX_M12DB = 2'b00,
    DCG_TX_M6DB  = 2'b01,
    DCG_TX_0DB   = 2'b10,
    DCG_TX_P6DB  = 2'b11
  } dcg_tx_gain_t;

endpackage

// *** hdl/dcg_codec_ctrl.sv ***
`timescale 1ns/1ps
// Summary of operation
// (R1) two volume registers at bb/bc, reset 00
// (R2) volume bits 7:6 pick transmit gain step
// (R3) line receive gain 7/23 dB, override 35
// (R4) mic receive gain 23/35, amp on 38/50
// (R5) override ignores bit 3 and amp enable
// (R6) gain control register at c7, reset 00
// (R7) select bit routes first or second line input
// (R8) bitstream full scale: all ones, all zeros
// (R9) sample words two's complement, saturate full scale
// (R10) receive decimates bitstream to 16-bit at 8 kHz
// (R11) decimator adds fixed 3.14 dB gain
// (R12) transmit noise shaper turns 16-bit words to bitstream
// (R13) spare bits read zero, ignore writes
`include "dcg_consts.svh"

module dcg_codec_ctrl
  import dcg_pkg::*;
#(
  parameter int DECIM_RATIO = `DCG_DECIM_RATIO,
  parameter int CLK_HZ      = `DCG_CLK_HZ,
  parameter int FS_HZ       = `DCG_FS_HZ
) (
  input  wire logic         mclk_in,
  input  wire logic         rstn_in,
  input  wire logic         ce_in,
  input  wire logic [7:0]   sfr_addr_in,
  input  wire logic [7:0]   sfr_wdata_in,
  input  wire logic         sfr_wr_in,
  input  wire logic         sfr_rd_in,
  output logic      [7:0]   sfr_rdata_out,
  output dcg_tx_gain_t      line_tx_gain_out,
  output dcg_tx_gain_t      mic_tx_gain_out,
  output dcg_rx_gain_t      line_rx_gain_out,
  output dcg_rx_gain_t      mic_rx_gain_out,
  output logic              line_input_select_out,
  output logic              mic_amplifier_enable_out,
  output logic              conv_bit_tick_out,
  input  wire logic         line_rx_bit_in,
  input  wire logic         mic_rx_bit_in,
  output logic      [15:0]  line_rx_pcm_out,
  output logic      [15:0]  mic_rx_pcm_out,
  output logic              rx_pcm_valid_out,
  input  wire logic [15:0]  line_tx_pcm_in,
  input  wire logic [15:0]  mic_tx_pcm_in,
  input  wire logic         tx_pcm_valid_in,
  output logic              line_tx_bit_out,
  output logic              mic_tx_bit_out
);

  localparam int BIT_DIV  = CLK_HZ / (FS_HZ * DECIM_RATIO);
  localparam int DIV_W    = $clog2(BIT_DIV + 1);
  localparam int CNT_W    = $clog2(DECIM_RATIO + 1);
  localparam int PCM_SH   = 15 - $clog2(DECIM_RATIO);

  logic [7:0]       line_vol_q;
  logic [7:0]       mic_vol_q;
  logic [7:0]       gain_ctrl_q;
  logic [DIV_W-1:0] div_q;
  logic             tick_q;
  logic [CNT_W-1:0] bit_cnt_q;
  logic [1:0]       rx_s1_q;
  logic [1:0]       rx_s2_q;
  logic [1:0]       tx_bit_q;
  logic [15:0]      rx_pcm_q [2];
  logic             rx_valid_q;

  function automatic dcg_rx_gain_t rx_gain(input logic is_mic, input logic rx_bit,
                                           input logic ovr, input logic amp);
    dcg_rx_gain_t g;
    g = DCG_RX_7DB;
    if (!is_mic) begin
      if (ovr) begin
        g = DCG_RX_35DB; // R5
      end else if (rx_bit) begin
        g = DCG_RX_23DB; // R3
      end else begin
        g = DCG_RX_7DB; // R3
      end
    end else begin
      if (ovr) begin
        g = DCG_RX_7DB; // R5
      end else if (amp) begin
        g = rx_bit ? DCG_RX_50DB : DCG_RX_38DB; // R4
      end else begin
        g = rx_bit ? DCG_RX_35DB : DCG_RX_23DB; // R4
      end
    end
    return g;
  endfunction

  function automatic logic [15:0] sat16(input logic signed [31:0] v);
    logic [15:0] r;
    r = v[15:0];
    if (v > 32'sd32767) begin
      r = `DCG_PCM_POS_FS; // R9
    end else if (v < -32'sd32768) begin
      r = `DCG_PCM_NEG_FS; // R9
    end
    return r;
  endfunction

  // register writes
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      line_vol_q  <= `DCG_VOL_RESET; // R1
      mic_vol_q   <= `DCG_VOL_RESET; // R1
      gain_ctrl_q <= `DCG_CTRL_RESET; // R6
    end else if (ce_in && sfr_wr_in) begin
      if (sfr_addr_in == `DCG_ADDR_LINE_VOL) begin
        line_vol_q <= sfr_wdata_in & `DCG_VOL_MASK; // R1 R13
      end else if (sfr_addr_in == `DCG_ADDR_MIC_VOL) begin
        mic_vol_q <= sfr_wdata_in & `DCG_VOL_MASK; // R1 R13
      end else if (sfr_addr_in == `DCG_ADDR_GAIN_CTRL) begin
        gain_ctrl_q <= sfr_wdata_in & `DCG_CTRL_MASK; // R6 R13
      end
    end
  end

  // register reads, unmapped reads zero
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      sfr_rdata_out <= 8'h00;
    end else if (ce_in && sfr_rd_in) begin
      if (sfr_addr_in == `DCG_ADDR_LINE_VOL) begin
        sfr_rdata_out <= line_vol_q; // R13
      end else if (sfr_addr_in == `DCG_ADDR_MIC_VOL) begin
        sfr_rdata_out <= mic_vol_q; // R13
      end else if (sfr_addr_in == `DCG_ADDR_GAIN_CTRL) begin
        sfr_rdata_out <= gain_ctrl_q; // R13
      end else begin
        sfr_rdata_out <= 8'h00;
      end
    end
  end

  // gain and routing controls to the analog front ends
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      line_tx_gain_out         <= DCG_TX_M12DB;
      mic_tx_gain_out          <= DCG_TX_M12DB;
      line_rx_gain_out         <= DCG_RX_7DB;
      mic_rx_gain_out          <= DCG_RX_23DB;
      line_input_select_out    <= 1'b0;
      mic_amplifier_enable_out <= 1'b0;
    end else if (ce_in) begin
      line_tx_gain_out <= dcg_tx_gain_t'(line_vol_q[`DCG_VOL_TX_HI:`DCG_VOL_TX_LO]); // R2
      mic_tx_gain_out  <= dcg_tx_gain_t'(mic_vol_q[`DCG_VOL_TX_HI:`DCG_VOL_TX_LO]); // R2
      line_rx_gain_out <= rx_gain(1'b0, line_vol_q[`DCG_VOL_RX_BIT],
                                  gain_ctrl_q[`DCG_CTRL_LINE_HI], 1'b0); // R3 R5
      mic_rx_gain_out  <= rx_gain(1'b1, mic_vol_q[`DCG_VOL_RX_BIT],
                                  gain_ctrl_q[`DCG_CTRL_MIC_LO],
                                  gain_ctrl_q[`DCG_CTRL_MIC_AMP]); // R4 R5
      line_input_select_out    <= gain_ctrl_q[`DCG_CTRL_LINE_SEL]; // R7
      mic_amplifier_enable_out <= gain_ctrl_q[`DCG_CTRL_MIC_AMP] &
                                  ~gain_ctrl_q[`DCG_CTRL_MIC_LO]; // R5
    end
  end

  // converter bit-rate tick, DECIM_RATIO ticks per 8 kHz sample
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (ce_in) begin
      if (div_q == DIV_W'(BIT_DIV - 1)) begin
        div_q  <= '0;
        tick_q <= 1'b1; // R10
      end else begin
        div_q  <= div_q + 1'b1;
        tick_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      conv_bit_tick_out <= 1'b0;
    end else if (ce_in) begin
      conv_bit_tick_out <= tick_q;
    end
  end

  // bitstream input synchronisers
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      rx_s1_q <= 2'b00;
      rx_s2_q <= 2'b00;
    end else if (ce_in) begin
      rx_s1_q <= {mic_rx_bit_in, line_rx_bit_in};
      rx_s2_q <= rx_s1_q;
    end
  end

  // decimation window position
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      bit_cnt_q  <= '0;
      rx_valid_q <= 1'b0;
    end else if (ce_in) begin
      rx_valid_q <= 1'b0;
      if (tick_q) begin
        if (bit_cnt_q == CNT_W'(DECIM_RATIO - 1)) begin
          bit_cnt_q  <= '0;
          rx_valid_q <= 1'b1; // R10
        end else begin
          bit_cnt_q <= bit_cnt_q + 1'b1;
        end
      end
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic [CNT_W-1:0]    ones_q;
      logic [CNT_W-1:0]    ones_total;
      logic signed [31:0]  lin;
      logic signed [31:0]  scaled;
      logic signed [15:0]  tx_word_q;
      logic signed [19:0]  acc_q;
      logic signed [19:0]  acc_d;
      logic signed [19:0]  fb;

      // ones density to signed word: all ones +fs, all zeros -fs
      always_comb begin
        ones_total = ones_q + CNT_W'(rx_s2_q[ch]); // R8
        lin = ((32'(ones_total) <<< 1) - 32'(DECIM_RATIO)) <<< PCM_SH; // R9
        scaled = (lin * 32'(`DCG_DEC_GAIN_NUM)) >>> `DCG_DEC_GAIN_SHIFT; // R11
      end

      always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
          ones_q       <= '0;
          rx_pcm_q[ch] <= 16'h0000;
        end else if (ce_in && tick_q) begin
          if (bit_cnt_q == CNT_W'(DECIM_RATIO - 1)) begin
            ones_q       <= '0;
            rx_pcm_q[ch] <= sat16(scaled); // R9 R10 R11
          end else begin
            ones_q <= ones_total;
          end
        end
      end

      // first-order noise shaper, feedback at word full scale
      always_comb begin
        fb    = tx_bit_q[ch] ? 20'sd32767 : -20'sd32768; // R8
        acc_d = acc_q + 20'(tx_word_q) - fb; // R12
      end

      always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
          tx_word_q <= '0;
        end else if (ce_in && tx_pcm_valid_in) begin
          tx_word_q <= (ch == 0) ? line_tx_pcm_in : mic_tx_pcm_in; // R12
        end
      end

      always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
          acc_q        <= '0;
          tx_bit_q[ch] <= 1'b0;
        end else if (ce_in && tick_q) begin
          acc_q        <= acc_d;
          tx_bit_q[ch] <= ~acc_d[19]; // R8 R12
        end
      end
    end
  endgenerate

  assign line_rx_pcm_out  = rx_pcm_q[0];
  assign mic_rx_pcm_out   = rx_pcm_q[1];
  assign rx_pcm_valid_out = rx_valid_q;
  assign line_tx_bit_out  = tx_bit_q[0];
  assign mic_tx_bit_out   = tx_bit_q[1];

endmodule

// *** verification/dcg_codec_ctrl_assertions.sv ***
`timescale 1ns/1ps
`include "dcg_consts.svh"
module dcg_chk
  import dcg_pkg::*;
(
  input wire logic         mclk_in,
  input wire logic         rstn_in,
  input wire logic         ce_in,
  input wire logic [7:0]   sfr_addr_in,
  input wire logic [7:0]   sfr_wdata_in,
  input wire logic         sfr_wr_in,
  input wire logic         sfr_rd_in,
  input wire logic [7:0]   sfr_rdata_out,
  input wire dcg_tx_gain_t line_tx_gain_out,
  input wire dcg_tx_gain_t mic_tx_gain_out,
  input wire dcg_rx_gain_t line_rx_gain_out,
  input wire dcg_rx_gain_t mic_rx_gain_out,
  input wire logic         line_input_select_out,
  input wire logic         mic_amplifier_enable_out,
  input wire logic [15:0]  line_rx_pcm_out,
  input wire logic         rx_pcm_valid_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  // accepted register write
  sequence wr_s(a);
    sfr_wr_in && ce_in && sfr_addr_in == a;
  endsequence
  line_tx_a: assert property (wr_s(`DCG_ADDR_LINE_VOL) |-> ##2
    line_tx_gain_out == $past(sfr_wdata_in[7:6], 2)) else $error("line tx gain");
  mic_tx_a: assert property (wr_s(`DCG_ADDR_MIC_VOL) |-> ##2
    mic_tx_gain_out == $past(sfr_wdata_in[7:6], 2)) else $error("mic tx gain");
  line_ovr_a: assert property (wr_s(`DCG_ADDR_GAIN_CTRL) ##0 sfr_wdata_in[5] |-> ##2
    line_rx_gain_out == DCG_RX_35DB) else $error("line override");
  mic_ovr_a: assert property (wr_s(`DCG_ADDR_GAIN_CTRL) ##0 sfr_wdata_in[1] |-> ##2
    mic_rx_gain_out == DCG_RX_7DB && !mic_amplifier_enable_out) else $error("mic override");
  line_sel_a: assert property (wr_s(`DCG_ADDR_GAIN_CTRL) |-> ##2
    line_input_select_out == $past(sfr_wdata_in[4], 2)) else $error("line select");
  spare_rd_a: assert property (sfr_rd_in && sfr_addr_in == `DCG_ADDR_GAIN_CTRL |=>
    (sfr_rdata_out & ~`DCG_CTRL_MASK) == 8'h00) else $error("spare bits");
  unmap_rd_a: assert property (sfr_rd_in && !(sfr_addr_in inside {`DCG_ADDR_LINE_VOL,
    `DCG_ADDR_MIC_VOL, `DCG_ADDR_GAIN_CTRL}) |=> sfr_rdata_out == 8'h00) else $error("unmapped");
  rd_hold_a: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out)) else $error("rdata");
  amp_gain_a: assert property (mic_amplifier_enable_out |->
    mic_rx_gain_out inside {DCG_RX_38DB, DCG_RX_50DB}) else $error("amp gain");
  valid_a: assert property (rx_pcm_valid_out |=> !rx_pcm_valid_out) else $error("valid");
  pcm_upd_a: assert property ($changed(line_rx_pcm_out) |-> rx_pcm_valid_out) else
    $error("pcm update");
endmodule

// *** verification/dcg_far_model.sv ***
`timescale 1ns/1ps
module dcg_far_model (
  input  wire logic       mclk_in,
  input  wire logic       tick_in,
  input  wire logic [1:0] mode_in,
  output logic            line_bit_out,
  output logic            mic_bit_out
);
  logic [1:0] cnt_q = 2'h0;
  always_ff @(posedge mclk_in) begin
    if (tick_in) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
  // zeros, ones, half and three quarter density, mic gets the inverse
  always_comb begin
    case (mode_in)
      2'h0: line_bit_out = 1'b0;
      2'h1: line_bit_out = 1'b1;
      2'h2: line_bit_out = cnt_q[0];
      default: line_bit_out = |cnt_q;
    endcase
  end
  assign mic_bit_out = ~line_bit_out;
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`include "dcg_consts.svh"
module tb_top
  import dcg_pkg::*;
;
  localparam int RATIO = `DCG_DECIM_RATIO;
  localparam int FS    = `DCG_FS_HZ;
  logic         mclk, rstn, ce, wr, rd, tvld, lrx, mrx, tick, vld, sel, amp, ltb, mtb;
  logic [1:0]   mode;
  logic [7:0]   addr, wd, rdat;
  logic [15:0]  ltx, mtx, lpcm, mpcm;
  dcg_tx_gain_t ltg, mtg;
  dcg_rx_gain_t lrg, mrg;
  int           err_count, samples_checked, n;
  logic [15:0]  pcm_exp [4] = '{`DCG_PCM_NEG_FS, `DCG_PCM_POS_FS, 16'h0000, 16'h5be0};
  logic [15:0]  mic_exp [4] = '{`DCG_PCM_POS_FS, `DCG_PCM_NEG_FS, 16'h0000, 16'ha420};

  dcg_codec_ctrl #(.DECIM_RATIO(RATIO), .CLK_HZ(RATIO * FS * 2), .FS_HZ(FS)) u_dcg_codec_ctrl (
    .mclk_in(mclk), .rstn_in(rstn), .ce_in(ce), .sfr_addr_in(addr), .sfr_wdata_in(wd),
    .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_rdata_out(rdat), .line_tx_gain_out(ltg),
    .mic_tx_gain_out(mtg), .line_rx_gain_out(lrg), .mic_rx_gain_out(mrg),
    .line_input_select_out(sel), .mic_amplifier_enable_out(amp), .conv_bit_tick_out(tick),
    .line_rx_bit_in(lrx), .mic_rx_bit_in(mrx), .line_rx_pcm_out(lpcm), .mic_rx_pcm_out(mpcm),
    .rx_pcm_valid_out(vld), .line_tx_pcm_in(ltx), .mic_tx_pcm_in(mtx), .tx_pcm_valid_in(tvld),
    .line_tx_bit_out(ltb), .mic_tx_bit_out(mtb));
  dcg_far_model u_far (.mclk_in(mclk), .tick_in(tick), .mode_in(mode),
    .line_bit_out(lrx), .mic_bit_out(mrx));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge mclk);
    wr = 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    addr = a;
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
    chk(rdat, e);
  endtask
  task automatic wvld(output int t);
    t = 0;
    repeat (600) begin
      @(negedge mclk);
      if (tick === 1'b1) t++;
      if (vld === 1'b1) break;
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    print_verdict();
  end

  initial begin
    {rstn, wr, rd, tvld, addr, wd, ltx, mtx, mode} = '0;
    ce = 1'b1;
    repeat (5) @(negedge mclk);
    rstn = 1'b1;
    rchk(`DCG_ADDR_LINE_VOL, `DCG_VOL_RESET);
    rchk(`DCG_ADDR_MIC_VOL, `DCG_VOL_RESET);
    rchk(`DCG_ADDR_GAIN_CTRL, `DCG_CTRL_RESET);
    ce = 1'b0;
    wreg(`DCG_ADDR_LINE_VOL, 8'hff);
    ce = 1'b1;
    rchk(`DCG_ADDR_LINE_VOL, `DCG_VOL_RESET);
    chk(ltg, DCG_TX_M12DB);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      wreg(`DCG_ADDR_LINE_VOL, {k[1:0], 6'h3f});
      wreg(`DCG_ADDR_MIC_VOL, {k[1:0], 6'h37});
      @(negedge mclk);
      chk(ltg, k[1:0]);
      chk(mtg, k[1:0]);
      rchk(`DCG_ADDR_LINE_VOL, {k[1:0], 6'h08});
    end
    $display("test tx gain done");
    for (int i = 0; i < 16; i++) begin
      wreg(`DCG_ADDR_LINE_VOL, {4'h0, i[0], 3'h0});
      wreg(`DCG_ADDR_MIC_VOL, {4'h0, i[0], 3'h0});
      wreg(`DCG_ADDR_GAIN_CTRL, {2'h0, i[3], i[0] ^ i[3], 1'b0, i[1], i[2], 1'b0});
      @(negedge mclk);
      chk(lrg, i[3] ? DCG_RX_35DB : i[0] ? DCG_RX_23DB : DCG_RX_7DB);
      chk(mrg, i[2] ? DCG_RX_7DB : 3'({i[1], i[0]}) + 3'h1);
      chk(sel, i[0] ^ i[3]);
      chk(amp, i[1] & !i[2]);
    end
    wreg(`DCG_ADDR_GAIN_CTRL, 8'hff);
    wreg(8'hbd, 8'hff);
    rchk(`DCG_ADDR_GAIN_CTRL, `DCG_CTRL_MASK);
    rchk(8'hbd, 8'h00);
    $display("test rx gain done");
    for (int m = 0; m < 4; m++) begin
      mode = m[1:0];
      repeat (3) wvld(n);
      chk(16'(n), 16'(RATIO));
      chk(lpcm, pcm_exp[m]);
      chk(mpcm, mic_exp[m]);
    end
    $display("test receive path done");
    ltx = `DCG_PCM_POS_FS;
    mtx = `DCG_PCM_NEG_FS;
    tvld = 1'b1;
    @(negedge mclk);
    tvld = 1'b0;
    repeat (16) @(negedge mclk);
    n = 0;
    repeat (128) begin
      @(negedge mclk);
      n += int'(ltb) - int'(mtb);
    end
    chk(n >= 100, 1'b1);
    chk(ltb, 1'b1);
    chk(mtb, 1'b0);
    $display("test transmit path done");
    print_verdict();
  end
endmodule

bind dcg_codec_ctrl dcg_chk u_dcg_chk (
  .mclk_in                  (mclk_in),
  .rstn_in                  (rstn_in),
  .ce_in                    (ce_in),
  .sfr_addr_in              (sfr_addr_in),
  .sfr_wdata_in             (sfr_wdata_in),
  .sfr_wr_in                (sfr_wr_in),
  .sfr_rd_in                (sfr_rd_in),
  .sfr_rdata_out            (sfr_rdata_out),
  .line_tx_gain_out         (line_tx_gain_out),
  .mic_tx_gain_out          (mic_tx_gain_out),
  .line_rx_gain_out         (line_rx_gain_out),
  .mic_rx_gain_out          (mic_rx_gain_out),
  .line_input_select_out    (line_input_select_out),
  .mic_amplifier_enable_out (mic_amplifier_enable_out),
  .line_rx_pcm_out          (line_rx_pcm_out),
  .rx_pcm_valid_out         (rx_pcm_valid_out)
);
